// ---- shg_gen.sv ----
// Purpose: Sync header stream generator with CRC-12 or FEC parity per multiblock
// Assumes: Input blocks are already scrambled; bit 63 of a block is sent first
// Notes: Parity of multiblock k rides in the stream of multiblock k+1
`include "shg_defines.svh"
`default_nettype none
// Summary of operation
// - Only CRC-12 and FEC; no CRC-3, no commands
// - CRC covers scrambled data of 32 blocks
// - Parity sent in the following multiblock
// - CRC error detection latency at least 46 blocks
// - CRC bits at 0-2,4-6,8-10,12-14 descending
// - Command bits 16-18,20,24-26 always zero
// - Fixed ones at 3,7,11,15,19,21,23
// - Positions 27-31 carry pilot 00001
// - Position 22 is end-of-extended-multiblock flag
// - CRC pilot unique, one-multiblock alignment
// - CRC polynomial 0x987 over 2048 bits
// - Parity state cleared before every multiblock
// - Payload bits only; read after 2048
// - FEC 26-bit parity sent next multiblock
// - FEC generator (x^17+1)(x^9+x^4+1)
// - FEC correction latency at least 58 blocks
// - FEC bits at 0-21, 23, 24-26
// - Sync header 01 sends one, 10 zero
// - Extended multiblock flag set every multiblock
module shg_gen (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic link_en,
  input wire shg_pkg::shg_mode_t mode_sel,
  input wire logic blk_valid,
  output logic blk_ready,
  input wire logic [`SHG_BLK_W-1:0] blk_data,
  input wire logic blk_first,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [`SHG_BLK_W-1:0] tx_data,
  output logic [1:0] tx_sh,
  output logic tx_mb_end,
  output logic [`SHG_FEC_W-1:0] last_parity
);
  typedef enum logic [1:0] {SHG_ST_IDLE, SHG_ST_FIRST, SHG_ST_RUN} shg_phase_t;

  typedef struct packed {
    shg_phase_t phase;
    shg_pkg::shg_mode_t mode;
    logic [`SHG_BLK_IDX_W-1:0] blk_idx;
    logic [`SHG_CRC_W-1:0] crc;
    logic [`SHG_FEC_W-1:0] fec;
    logic [31:0] stream;
    logic [`SHG_FEC_W-1:0] last_parity;
  } shg_state_t;

  shg_state_t st_reg, st_next;
  logic buf_ready;
  logic accept;
  logic [`SHG_CRC_W-1:0] crc_blk;
  logic [`SHG_FEC_W-1:0] fec_blk;
  logic [31:0] crc_stream;
  logic [31:0] fec_stream;
  logic stream_bit;
  shg_pkg::shg_word_t buf_in, buf_out;

  // Serial LFSR step folded over one 64-bit block, MSB first
  function automatic logic [`SHG_CRC_W-1:0] crc_step(input logic [`SHG_CRC_W-1:0] s,
                                                     input logic [`SHG_BLK_W-1:0] d);
    logic [`SHG_CRC_W-1:0] r;
    logic fb;
    r = s;
    for (int i = `SHG_BLK_W - 1; i >= 0; i--) begin
      fb = r[`SHG_CRC_W-1] ^ d[i];
      r = {r[`SHG_CRC_W-2:0], 1'b0} ^ (fb ? `SHG_CRC_POLY : '0);
    end
    return r;
  endfunction

  function automatic logic [`SHG_FEC_W-1:0] fec_step(input logic [`SHG_FEC_W-1:0] s,
                                                     input logic [`SHG_BLK_W-1:0] d);
    logic [`SHG_FEC_W-1:0] r;
    logic fb;
    r = s;
    for (int i = `SHG_BLK_W - 1; i >= 0; i--) begin
      fb = r[`SHG_FEC_W-1] ^ d[i];
      r = {r[`SHG_FEC_W-2:0], 1'b0} ^ (fb ? `SHG_FEC_POLY : '0);
    end
    return r;
  endfunction

  assign accept = blk_valid && blk_ready;
  // Back-pressure from the lane stalls accepting new blocks
  assign blk_ready = (st_reg.phase != SHG_ST_IDLE) && buf_ready;

  // The state is cleared at the first block, so the step starts from zero
  always_comb begin
    if (blk_first || st_reg.blk_idx == '0) begin
      crc_blk = crc_step('0, blk_data);
      fec_blk = fec_step('0, blk_data);
    end else begin
      crc_blk = crc_step(st_reg.crc, blk_data);
      fec_blk = fec_step(st_reg.fec, blk_data);
    end
  end

  // Stream bit 0 goes out first; vector index equals stream position
  always_comb begin
    crc_stream = '0; // Command bits stay zero
    {crc_stream[0], crc_stream[1], crc_stream[2]} = st_reg.last_parity[11:9];
    {crc_stream[4], crc_stream[5], crc_stream[6]} = st_reg.last_parity[8:6];
    {crc_stream[8], crc_stream[9], crc_stream[10]} = st_reg.last_parity[5:3];
    {crc_stream[12], crc_stream[13], crc_stream[14]} = st_reg.last_parity[2:0];
    {crc_stream[3], crc_stream[7], crc_stream[11], crc_stream[15]} = 4'hf;
    {crc_stream[19], crc_stream[21], crc_stream[23]} = 3'h7;
    crc_stream[`SHG_EOEMB_POS] = 1'b1; // Only E=1 supported
    {crc_stream[27], crc_stream[28], crc_stream[29], crc_stream[30], crc_stream[31]} = `SHG_PILOT;
  end

  always_comb begin
    fec_stream = '0;
    for (int p = 0; p < 22; p++) begin
      fec_stream[p] = st_reg.last_parity[25 - p];
    end
    fec_stream[23] = st_reg.last_parity[3];
    {fec_stream[24], fec_stream[25], fec_stream[26]} = st_reg.last_parity[2:0];
    fec_stream[`SHG_EOEMB_POS] = 1'b1;
    {fec_stream[27], fec_stream[28], fec_stream[29], fec_stream[30], fec_stream[31]} = `SHG_PILOT;
  end

  always_comb begin
    st_next = st_reg;
    case (st_reg.phase)
      SHG_ST_IDLE: begin
        // Mode is sampled only while the link is disabled
        st_next.mode = mode_sel;
        st_next.blk_idx = '0;
        st_next.last_parity = '0;
        if (link_en) begin
          st_next.phase = SHG_ST_FIRST;
        end
      end
      SHG_ST_FIRST, SHG_ST_RUN: begin
        if (!link_en) begin
          st_next.phase = SHG_ST_IDLE;
        end else if (accept) begin
          st_next.crc = crc_blk;
          st_next.fec = fec_blk;
          st_next.blk_idx = (blk_first ? `SHG_BLK_IDX_W'(0) : st_reg.blk_idx) + `SHG_BLK_IDX_W'(1);
          if (blk_first || st_reg.blk_idx == '0) begin
            st_next.stream = (st_reg.mode == shg_pkg::SHG_MODE_CRC) ? crc_stream : fec_stream;
          end
          if ((blk_first ? `SHG_BLK_IDX_W'(0) : st_reg.blk_idx) == `SHG_LAST_BLK) begin
            // Latch parity for the following multiblock
            // Held back a whole multiblock, so the far check cannot be earlier
            st_next.last_parity = (st_reg.mode == shg_pkg::SHG_MODE_CRC) ?
                                  `SHG_FEC_W'(crc_blk) : fec_blk;
            st_next.phase = SHG_ST_RUN;
          end
        end
      end
      default: begin
        st_next.phase = SHG_ST_IDLE;
      end
    endcase
  end

  // Bit for this block: fresh stream at block 0, stored stream after
  always_comb begin
    if (blk_first || st_reg.blk_idx == '0) begin
      stream_bit = (st_reg.mode == shg_pkg::SHG_MODE_CRC) ? crc_stream[0] : fec_stream[0];
    end else begin
      stream_bit = st_reg.stream[st_reg.blk_idx];
    end
  end

  assign buf_in.data = blk_data;
  assign buf_in.sh = stream_bit ? `SHG_SH_ONE : `SHG_SH_ZERO;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  shg_skid_buf u_buf (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .in_valid(accept),
    .in_ready(buf_ready),
    .in_word(buf_in),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_word(buf_out)
  );

  assign tx_data = buf_out.data;
  assign tx_sh = buf_out.sh;
  assign tx_mb_end = 1'b0;
  assign last_parity = st_reg.last_parity;
endmodule
`default_nettype wire

// ---- shg_defines.svh ----
// Purpose: Constants for the sync header stream parity generator
// Assumes: One 64-bit scrambled block per accepted beat
// Notes: Stream bit n is sent in block n of a multiblock
`ifndef SHG_DEFINES_SVH
`define SHG_DEFINES_SVH
`define SHG_BLK_W 64
`define SHG_BLKS_PER_MB 32
`define SHG_BLK_IDX_W 5
`define SHG_LAST_BLK 5'h1f
`define SHG_CRC_W 12
// Feedback mask without the x^12 term; 0x987 is the same polynomial in implicit-one form
`define SHG_CRC_POLY 12'h30f
`define SHG_FEC_W 26
`define SHG_FEC_POLY 26'h0220211
`define SHG_SH_ONE 2'h1
`define SHG_SH_ZERO 2'h2
`define SHG_PILOT 5'h01
`define SHG_EOEMB_POS 22
`define SHG_CRC_FILL 7'h7f
`endif

// ---- shg_pkg.sv ----
// Purpose: Types for the sync header stream parity generator
// Assumes: Included defines give all widths
// Notes: Mode is static while the link is enabled
`include "shg_defines.svh"
`default_nettype none
package shg_pkg;
  typedef enum logic {SHG_MODE_CRC, SHG_MODE_FEC} shg_mode_t;
  typedef struct packed {
    logic [`SHG_BLK_W-1:0] data;
    logic [1:0] sh;
  } shg_word_t;
endpackage
`default_nettype wire

// ---- shg_skid_buf.sv ----
// Purpose: Two-entry buffer between the generator and the lane
// Assumes: Same clock on both sides
// Notes: in_ready depends only on registered fill, so no combinational path back
`include "shg_defines.svh"
`default_nettype none
module shg_skid_buf (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire shg_pkg::shg_word_t in_word,
  output logic out_valid,
  input wire logic out_ready,
  output shg_pkg::shg_word_t out_word
);
  typedef struct packed {
    shg_pkg::shg_word_t [1:0] mem;
    logic rd_ptr;
    logic wr_ptr;
    logic [1:0] count;
  } shg_buf_state_t;
  shg_buf_state_t st_reg, st_next;
  logic push, pop;

  assign in_ready = (st_reg.count != 2'h2);
  assign out_valid = (st_reg.count != 2'h0);
  assign out_word = st_reg.mem[st_reg.rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr_ptr] = in_word;
      st_next.wr_ptr = ~st_reg.wr_ptr;
    end
    if (pop) begin
      st_next.rd_ptr = ~st_reg.rd_ptr;
    end
    if (push && !pop) begin
      st_next.count = st_reg.count + 2'h1;
    end else if (pop && !push) begin
      st_next.count = st_reg.count - 2'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end
endmodule
`default_nettype wire

// ---- shg_gen_asserts.sv ----
// Purpose: Port checks for the sync header stream generator
// Assumes: clk_en held high; no restart inside a multiblock
// Notes: Block index is counted at the output handshake
`include "shg_defines.svh"
`default_nettype none
module shg_gen_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic link_en,
  input wire shg_pkg::shg_mode_t mode_sel,
  input wire logic blk_valid,
  input wire logic blk_ready,
  input wire logic [`SHG_BLK_W-1:0] blk_data,
  input wire logic blk_first,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [`SHG_BLK_W-1:0] tx_data,
  input wire logic [1:0] tx_sh,
  input wire logic tx_mb_end,
  input wire logic [`SHG_FEC_W-1:0] last_parity
);
  logic [4:0] idx_reg;
  logic first_reg;
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !link_en) begin
      idx_reg <= 5'h00;
      first_reg <= 1'b1;
    end else if (tx_valid && tx_ready) begin
      idx_reg <= idx_reg + 5'h01;
      if (idx_reg == 5'h1f)
        first_reg <= 1'b0;
    end
  end
  wire logic crc = mode_sel == shg_pkg::SHG_MODE_CRC;
  wire logic one = tx_sh == 2'h1;
  wire logic zro = tx_sh == 2'h2;
  wire logic ones = idx_reg inside {3, 7, 11, 15, 19, 21, 23};
  wire logic cmd = idx_reg inside {[16:18], 20, [24:26]};
  wire logic par = crc ? idx_reg inside {[0:2], [4:6], [8:10], [12:14]} : idx_reg < 22 || idx_reg inside {[23:26]};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_take_empty;
    blk_valid && blk_ready && !tx_valid;
  endsequence
  a_sh_legal: assert property (tx_valid |-> one || zro) else $error("bad header");
  a_stall_holds: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_sh))
    else $error("word moved");
  a_answer_next: assert property (s_take_empty |=> tx_valid && tx_data == $past(blk_data))
    else $error("late word");
  a_pilot_tail: assert property (tx_valid && idx_reg >= 5'h1b |-> (idx_reg == 5'h1f ? one : zro))
    else $error("pilot");
  a_eoemb_set: assert property (tx_valid && idx_reg == 5'h16 |-> one) else $error("eoemb");
  a_crc_ones: assert property (tx_valid && crc && ones |-> one) else $error("fixed one");
  a_cmd_zero: assert property (tx_valid && crc && cmd |-> zro) else $error("command bit");
  a_first_zero: assert property (tx_valid && first_reg && par |-> zro) else $error("parity");
  a_idle_ready: assert property (!link_en ##1 !link_en |-> !blk_ready) else $error("ready");
endmodule
`default_nettype wire

// ---- shg_rx_model.sv ----
// Purpose: Lane receiver standing at the generator output
// Assumes: One word per handshake
// Notes: Slow mode stalls three cycles in four to fill the buffer
`default_nettype none
module shg_rx_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [63:0] tx_data,
  input wire logic [1:0] tx_sh,
  output logic tx_ready,
  output logic got,
  output logic [63:0] got_data,
  output logic [1:0] got_sh
);
  logic [1:0] cnt_reg;
  always_ff @(posedge sys_clk) begin
    cnt_reg <= rst_n ? cnt_reg + 2'h1 : 2'h0;
    got <= rst_n && tx_valid && tx_ready;
    got_data <= tx_data;
    got_sh <= tx_sh;
  end
  assign tx_ready = !slow || cnt_reg == 2'h3;
endmodule
`default_nettype wire

// ---- shg_gen_bench.sv ----
// Purpose: Self-checking bench for the sync header stream generator
// Assumes: Parity is MSB first, zero start, no final xor
// Notes: Three multiblocks per row so parity rides one multiblock late
`include "shg_defines.svh"
`default_nettype none
module shg_gen_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam shg_pkg::shg_mode_t CRC = shg_pkg::SHG_MODE_CRC;
  localparam shg_pkg::shg_mode_t FEC = shg_pkg::SHG_MODE_FEC;
  typedef struct packed {shg_pkg::shg_mode_t mode; logic [31:0] seed; logic slow;} shg_row_t;
  logic sys_clk, rst_n, clk_en, link_en, blk_valid, blk_first, slow, blk_ready, tx_valid, tx_ready, tx_mb_end, got;
  shg_pkg::shg_mode_t mode_sel;
  logic [63:0] blk_data, tx_data, got_data;
  logic [1:0] tx_sh, got_sh;
  logic [25:0] last_parity;
  int err_total = 0;
  int checked = 0;
  logic [65:0] exp_q[$];
  shg_row_t rows[4] = '{'{CRC, 32'h12345678, 1'b0}, '{FEC, 32'h9abcdef0, 1'b0},
                        '{CRC, 32'hffffffff, 1'b1}, '{FEC, 32'hffffffff, 1'b1}};
  shg_gen uut (.*);
  shg_rx_model far_end (.*);
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic chk(logic [65:0] seen, logic [65:0] want);
    checked++;
    if (seen !== want) begin
      err_total++;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic wrap_up;
    if (err_total == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [25:0] step(shg_pkg::shg_mode_t m, logic [25:0] s, logic [63:0] d);
    logic c, fb;
    c = m == CRC;
    for (int b = 63; b >= 0; b--) begin
      fb = d[b] ^ (c ? s[11] : s[25]);
      s = {s[24:0], 1'b0} ^ (fb ? (c ? 26'h000030f : 26'h0220211) : 26'h0);
      if (c)
        s[25:12] = 14'h0;
    end
    return s;
  endfunction
  // Position 0 of the stream sits in the top bit
  function automatic logic [31:0] strm(shg_pkg::shg_mode_t m, logic [25:0] p);
    if (m == CRC)
      return {p[11:9], 1'b1, p[8:6], 1'b1, p[5:3], 1'b1, p[2:0], 1'b1, 8'h17, 8'h01};
    return {p[25:4], 1'b1, p[3], p[2:0], 5'h01};
  endfunction
  task automatic run_row(shg_row_t r);
    logic [25:0] acc, par;
    logic [63:0] d;
    logic [31:0] s;
    link_en <= 1'b0;
    mode_sel <= r.mode;
    slow <= r.slow;
    repeat (3) @(posedge sys_clk);
    link_en <= 1'b1;
    repeat (2) @(posedge sys_clk);
    par = 26'h0;
    for (int m = 0; m < 3; m++) begin
      s = strm(r.mode, par);
      acc = 26'h0;
      for (int i = 0; i < 32; i++) begin
        d = {r.seed ^ 32'(m), 24'(m), 8'(i)};
        acc = step(r.mode, acc, d);
        exp_q.push_back({d, s[31-i] ? 2'h1 : 2'h2});
        blk_valid <= 1'b1;
        blk_data <= d;
        blk_first <= i == 0;
        do @(negedge sys_clk); while (blk_ready !== 1'b1);
        @(posedge sys_clk);
      end
      par = acc;
    end
    blk_valid <= 1'b0;
    repeat (400) if (exp_q.size() != 0) @(posedge sys_clk);
    chk(66'(exp_q.size()), 66'h0);
  endtask
  always @(posedge sys_clk) if (got) chk({got_data, got_sh}, exp_q.size() != 0 ? exp_q.pop_front() : '1);
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    link_en = 1'b0;
    mode_sel = CRC;
    blk_valid = 1'b0;
    blk_data = 64'h0;
    blk_first = 1'b0;
    slow = 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    chk({64'h0, tx_valid, blk_ready}, 66'h0);
    @(posedge sys_clk);
    foreach (rows[k]) run_row(rows[k]);
    // Reset with a word offered: it must never be taken
    blk_valid <= 1'b1;
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    blk_valid <= 1'b0;
    @(negedge sys_clk);
    chk({64'h0, tx_valid, blk_ready}, 66'h0);
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    wrap_up();
  end
endmodule
bind shg_gen shg_gen_asserts u_chk (.*);
`default_nettype wire
